// >>> hw/prm_defs.vh
// constants for the portrait rotation mapper
`ifndef PRM_DEFS_VH
`define PRM_DEFS_VH
`define PRM_ADDR_W 21
`define PRM_VIRT_DIM 1024
`define PRM_VIRT_LOG2 10
`define PRM_MEM_512K 2'b00
`define PRM_MEM_2M 2'b01
`define PRM_MEM_MASK_512K 21'h07ffff
`define PRM_MEM_MASK_2M 21'h1fffff
`define PRM_BPP_8 2'b00
`define PRM_BPP_16 2'b01
`define PRM_OFF_CTRL 12'h000
`define PRM_OFF_START 12'h004
`define PRM_OFF_PAN 12'h008
`define PRM_OFF_PANEL 12'h00c
`define PRM_OFF_STATUS 12'h010
`define PRM_OFF_HFB 12'h014
`define PRM_CTRL_ROT 0
`define PRM_CTRL_BPP_LO 1
`define PRM_CTRL_MEM_LO 3
`define PRM_CTRL_DUAL 5
`define PRM_CTRL_COLOR 6
`define PRM_CTRL_SPLIT 7
`define PRM_CTRL_RST 32'h00000000
`define PRM_START_RST 32'h00000000
`define PRM_PANEL_RST 32'h00000000
`endif

// >>> hw/prm_rotate.v
// coordinate rotation of one host byte address
`timescale 1ns/1ps
`include "prm_defs.vh"
module prm_rotate #(
    parameter DIM_LOG2 = 10
) (
    input wire [20:0] addr_in,
    input wire bpp16,
    output reg [20:0] addr_out
);
    reg [DIM_LOG2-1:0] x;
    reg [DIM_LOG2-1:0] y;
    reg [DIM_LOG2-1:0] nx;
    reg byte_sel;
    always @*
    begin
        x = {DIM_LOG2{1'b0}};
        y = {DIM_LOG2{1'b0}};
        byte_sel = 1'b0;
        addr_out = addr_in;
        if (bpp16)
        begin
            byte_sel = addr_in[0];
            x = addr_in[DIM_LOG2:1];
            y = addr_in[2*DIM_LOG2:DIM_LOG2+1];
        end
        else
        begin
            x = addr_in[DIM_LOG2-1:0];
            y = addr_in[2*DIM_LOG2-1:DIM_LOG2];
        end
        // clockwise turn: stored row is x, stored column is 1023-y
        nx = ~y;
        if (bpp16)
            addr_out = {x, nx, byte_sel};
        else
            addr_out = {addr_in[20], x, nx};
    end
endmodule

// >>> hw/prm_top.v
// portrait rotation mapper: host buffer access remap with apb control
//
// Notes on behaviour
// - rotation on: host accesses remapped so stored image turns 90 degrees clockwise
// - mapping spans a fixed 1024 by 1024 pixel virtual image
// - host order A B C D lands in memory as C A D B
// - one pixel pan adds or subtracts 1024 or 512 to start
// - start step scrolls two lines at 8 bpp, one at 16 bpp
// - pixel panning step scrolls one line vertically in rotated mode
// - dual panel half-frame buffer sits at memory top, wh/4 or wh/16
// - physical memory is 512K or 2M bytes only
// - cursor takes 1K, ink takes wh/4, only one active
// - rotation only at 8 and 16 bpp
// - cursor and ink are not rotated; software turns rotation off
// - rotated split screens appear side by side
// - fixed 2M decode, 512K mirrored through it
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "prm_defs.vh"
module prm_top #(
    parameter DIM_LOG2 = `PRM_VIRT_LOG2
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire host_cs_n,
    input wire host_mem_sel,
    input wire host_valid,
    input wire host_write,
    input wire [20:0] host_byte_addr,
    input wire [15:0] host_wdata,
    output reg [15:0] host_rdata,
    output reg host_ack,
    output reg mem_req,
    output reg mem_we,
    output reg [20:0] mem_addr,
    output reg [15:0] mem_wdata,
    input wire [15:0] mem_rdata,
    input wire mem_done,
    output reg [9:0] win_line,
    output reg [9:0] win_col,
    output reg [9:0] win_split_col,
    output reg [20:0] hfb_base,
    output reg win_vertical_split
);
    localparam ST_IDLE = 3'b001;
    localparam ST_MEM = 3'b010;
    localparam ST_ACK = 3'b100;

    reg [31:0] ctrl_q;
    reg [31:0] start_q;
    reg [3:0] pan_q;
    reg [31:0] panel_q;
    reg [2:0] state_q;
    reg [2:0] state_d;
    reg [31:0] err_cnt_q;
    reg [20:0] hfb_size;
    reg [20:0] mem_mask;
    reg [20:0] rot_addr;
    reg [20:0] phys_addr;
    reg rot_on;
    reg rot_ok;
    reg mode_ok;
    reg [31:0] rd_mux;
    reg addr_hit;
    wire bpp16;
    wire [1:0] mem_sz;
    wire [20:0] rot_out;
    wire [9:0] w_line;
    wire [9:0] w_col;
    wire [9:0] w_split;
    wire [19:0] area;

    assign bpp16 = ctrl_q[`PRM_CTRL_BPP_LO];
    assign mem_sz = ctrl_q[`PRM_CTRL_MEM_LO+1:`PRM_CTRL_MEM_LO];
    assign area = panel_q[9:0] * panel_q[25:16];

    prm_rotate #(
        .DIM_LOG2(DIM_LOG2)
    ) u_rot (
        .addr_in(host_byte_addr),
        .bpp16(bpp16),
        .addr_out(rot_out)
    );

    prm_window u_win (
        .start_words(start_q[19:0]),
        .pixel_pan(pan_q),
        .bpp16(bpp16),
        .split_line(panel_q[9:0]),
        .first_line(w_line),
        .first_col(w_col),
        .split_col(w_split)
    );

    always @*
    begin
        // only the two documented depths may be rotated
        mode_ok = (ctrl_q[2:1] == `PRM_BPP_8) || (ctrl_q[2:1] == `PRM_BPP_16);
        rot_ok = ctrl_q[`PRM_CTRL_ROT] && mode_ok;
        rot_on = rot_ok;
        // 512K of memory repeats through the whole 2M window
        if (mem_sz == `PRM_MEM_2M)
            mem_mask = `PRM_MEM_MASK_2M;
        else
            mem_mask = `PRM_MEM_MASK_512K;
        // cursor and ink space is reached with rotation off, so no bypass needed
        if (rot_on)
            rot_addr = rot_out;
        else
            rot_addr = host_byte_addr;
        phys_addr = rot_addr & mem_mask;
        if (ctrl_q[`PRM_CTRL_COLOR])
            hfb_size = {3'b000, area[19:2]};
        else
            hfb_size = {5'b00000, area[19:4]};
    end

    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
                if (host_valid && !host_cs_n && host_mem_sel)
                    state_d = ST_MEM;
            ST_MEM:
                if (mem_done)
                    state_d = ST_ACK;
            ST_ACK:
                state_d = ST_IDLE;
            default:
                state_d = ST_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_IDLE;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 21'h000000;
            mem_wdata <= 16'h0000;
            host_rdata <= 16'h0000;
            host_ack <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            host_ack <= 1'b0;
            if (state_q == ST_IDLE && state_d == ST_MEM)
            begin
                // address captured once so a mode change mid access is harmless
                mem_req <= 1'b1;
                mem_we <= host_write;
                mem_addr <= phys_addr;
                mem_wdata <= host_wdata;
            end
            if (state_q == ST_MEM && mem_done)
            begin
                mem_req <= 1'b0;
                host_rdata <= mem_rdata;
                host_ack <= 1'b1;
            end
        end
    end

    always @*
    begin
        addr_hit = 1'b1;
        rd_mux = 32'h00000000;
        case (paddr)
            `PRM_OFF_CTRL: rd_mux = ctrl_q;
            `PRM_OFF_START: rd_mux = start_q;
            `PRM_OFF_PAN: rd_mux = {28'h0000000, pan_q};
            `PRM_OFF_PANEL: rd_mux = panel_q;
            `PRM_OFF_STATUS: rd_mux = {26'h0000000, mode_ok, rot_on, state_q, mem_req};
            `PRM_OFF_HFB: rd_mux = {11'h000, hfb_base};
            default: addr_hit = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= `PRM_CTRL_RST;
            start_q <= `PRM_START_RST;
            pan_q <= 4'h0;
            panel_q <= `PRM_PANEL_RST;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            err_cnt_q <= 32'h00000000;
        end
        else
        begin
            // one wait state: pready rises in the second access cycle
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_hit;
            if (psel && penable && !pready && !pwrite)
                prdata <= rd_mux;
            if (psel && penable && !pready && pwrite && addr_hit)
            begin
                case (paddr)
                    `PRM_OFF_CTRL: ctrl_q <= {24'h000000, pwdata[7:0]};
                    `PRM_OFF_START: start_q <= {12'h000, pwdata[19:0]};
                    `PRM_OFF_PAN: pan_q <= pwdata[3:0];
                    `PRM_OFF_PANEL: panel_q <= {6'h00, pwdata[25:16], 6'h00, pwdata[9:0]};
                    default: err_cnt_q <= err_cnt_q + 32'h00000001;
                endcase
            end
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            win_line <= 10'h000;
            win_col <= 10'h000;
            win_split_col <= 10'h000;
            hfb_base <= 21'h000000;
            win_vertical_split <= 1'b0;
        end
        else
        begin
            win_line <= rot_on ? w_line : 10'h000;
            win_col <= rot_on ? w_col : 10'h000;
            win_split_col <= w_split;
            win_vertical_split <= rot_on && ctrl_q[`PRM_CTRL_SPLIT];
            if (ctrl_q[`PRM_CTRL_DUAL])
                hfb_base <= mem_mask + 21'h000001 - hfb_size;
            else
                hfb_base <= mem_mask + 21'h000001;
        end
    end
endmodule

// >>> hw/prm_window.v
// rotated display window origin and split placement
`timescale 1ns/1ps
`include "prm_defs.vh"
module prm_window (
    input wire [19:0] start_words,
    input wire [3:0] pixel_pan,
    input wire bpp16,
    input wire [9:0] split_line,
    output reg [9:0] first_line,
    output reg [9:0] first_col,
    output reg [9:0] split_col
);
    reg [10:0] line_pix;
    always @*
    begin
        // each start word is one line at 16 bpp, two at 8 bpp
        if (bpp16)
            line_pix = {1'b0, start_words[9:0]};
        else
            line_pix = {start_words[9:0], 1'b0};
        first_line = line_pix[9:0] + {6'h00, pixel_pan};
        // a 1024-pixel step of start address moves one column
        if (bpp16)
            first_col = start_words[19:10];
        else
            first_col = start_words[18:9];
        split_col = split_line;
    end
endmodule

// >>> sim/prm_chk.sv
// port assertions for the rotation mapper
`timescale 1ns/1ps
module prm_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic host_cs_n,
    input wire logic host_mem_sel,
    input wire logic host_valid,
    input wire logic host_write,
    input wire logic [15:0] host_wdata,
    input wire logic [15:0] host_rdata,
    input wire logic host_ack,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [20:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_done
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_done;
        mem_req && mem_done;
    endsequence
    apb_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    apb_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    err_qual_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    host_take_a: assert property ($rose(host_valid) && !host_cs_n && host_mem_sel |=> mem_req)
        else $error("buffer access not taken");
    req_hold_a: assert property (mem_req && !mem_done |=> mem_req && $stable(mem_addr))
        else $error("memory request dropped");
    ack_done_a: assert property (s_done |=> host_ack && !mem_req)
        else $error("ack missing after done");
    ack_pulse_a: assert property (host_ack |=> !host_ack)
        else $error("ack longer than one cycle");
    read_data_a: assert property ((s_done and !mem_we) |=> host_rdata == $past(mem_rdata))
        else $error("read data not returned");
    write_data_a: assert property (mem_req |-> mem_we == host_write && (!mem_we || mem_wdata == host_wdata))
        else $error("write data altered");
endmodule
bind prm_top prm_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .host_cs_n, .host_mem_sel,
    .host_valid, .host_write, .host_wdata, .host_rdata, .host_ack, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_done);

// >>> sim/prm_mem_model.sv
// buffer memory partner answering mapper requests
`timescale 1ns/1ps
module prm_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_req,
    input wire logic [20:0] mem_addr,
    input wire logic [2:0] lat,
    output logic [15:0] mem_rdata,
    output logic mem_done
);
    logic [2:0] cnt_q;
    // read data is a pattern of the address, so a wrong address shows up
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 3'h0;
            mem_done <= 1'b0;
            mem_rdata <= 16'h0000;
        end
        else if (mem_req && !mem_done && cnt_q >= lat)
        begin
            cnt_q <= 3'h0;
            mem_done <= 1'b1;
            mem_rdata <= mem_addr[15:0] ^ 16'h5a5a;
        end
        else
        begin
            cnt_q <= (mem_req && !mem_done) ? cnt_q + 3'h1 : 3'h0;
            mem_done <= 1'b0;
            // released bus: never leave the last value standing
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// >>> sim/prm_tb_top.sv
// testbench for the portrait rotation mapper
`timescale 1ns/1ps
`include "prm_defs.vh"
module prm_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic host_cs_n, host_mem_sel, host_valid, host_write, host_ack, mem_req, mem_we, mem_done, win_vertical_split;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [20:0] host_byte_addr, mem_addr, hfb_base;
    logic [15:0] host_wdata, host_rdata, mem_wdata, mem_rdata;
    logic [9:0] win_line, win_col, win_split_col;
    logic [2:0] lat;
    int fail_count, n_checks;
    prm_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .host_cs_n, .host_mem_sel, .host_valid, .host_write, .host_byte_addr, .host_wdata, .host_rdata, .host_ack,
        .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_done, .win_line, .win_col, .win_split_col,
        .hfb_base, .win_vertical_split);
    prm_mem_model u_mem (.pclk, .presetn, .mem_req, .mem_addr, .lat, .mem_rdata, .mem_done);
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task tmo;
        fail_count++;
        conclude;
    endtask
    // apb transfer; result lands in rd and er
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do @(posedge pclk); while (!pready && ++i < 20);
        if (!pready)
            tmo;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // one buffer access, checks address seen by memory and read data
    task host(input logic w, input logic [20:0] a, input logic [15:0] d, input logic [20:0] ea);
        int i;
        host_valid <= 1'b1;
        host_write <= w;
        host_byte_addr <= a;
        host_wdata <= d;
        i = 0;
        do @(posedge pclk); while (!mem_req && ++i < 40);
        if (!mem_req)
            tmo;
        chk(mem_addr, ea);
        do @(posedge pclk); while (!host_ack && ++i < 40);
        if (!host_ack)
            tmo;
        if (!w)
            chk(host_rdata, ea[15:0] ^ 16'h5a5a);
        host_valid <= 1'b0;
        @(posedge pclk);
    endtask
    task s_regs;
        apb(0, `PRM_OFF_CTRL, 0);
        chk(rd, `PRM_CTRL_RST);
        apb(1, `PRM_OFF_START, 32'h000fffff);
        apb(0, `PRM_OFF_START, 0);
        chk(rd, 32'h000fffff);
        apb(0, 12'h020, 0);
        chk(er, 1'b1);
    endtask
    // rotation off, mirror in 512K, unsupported depth left alone
    task s_pass;
        apb(1, `PRM_OFF_CTRL, {27'h0, `PRM_MEM_512K, `PRM_BPP_16, 1'b0});
        lat <= 3'h5;
        // rotation off is also how cursor and ink space is reached
        host(1, 21'h1abcde, 16'h1234, 21'h1abcde & `PRM_MEM_MASK_512K);
        host(0, 21'h0f0f0f, 16'h0000, 21'h0f0f0f & `PRM_MEM_MASK_512K);
        apb(1, `PRM_OFF_CTRL, {27'h0, `PRM_MEM_512K, 2'b10, 1'b1});
        host(0, 21'h1abcde, 16'h0000, 21'h1abcde & `PRM_MEM_MASK_512K);
        lat <= 3'h0;
    endtask
    // one point in each quadrant, both depths, writes and reads
    task s_rot;
        logic [9:0] y, x;
        for (int b = 0; b < 2; b++)
        begin
            apb(1, `PRM_OFF_CTRL, {27'h0, `PRM_MEM_2M, b[1:0], 1'b1});
            for (int i = 0; i < 4; i++)
            begin
                // 1024 pixel pitch, addresses kept inside fitted 2M
                y = {i[1], 9'h0a5};
                x = {i[0], 9'h13c};
                if (b == 1)
                    host(i[0], {y, x, 1'b1}, 16'hc3a0, {x, ~y, 1'b1});
                else
                    host(i[0], {1'b1, y, x}, 16'h0c3a, {1'b1, x, ~y});
            end
        end
    endtask
    // window origin, pan and half-frame base in both depths, split at 16 bpp only
    task s_win;
        apb(1, `PRM_OFF_PANEL, 32'h014000f0);
        apb(1, `PRM_OFF_PAN, 32'h00000003);
        apb(1, `PRM_OFF_CTRL, 32'h000000eb);
        apb(1, `PRM_OFF_START, 32'h00000710);
        chk(win_line, 10'h313);
        chk(win_col, 10'h001);
        chk(win_split_col, 10'h0f0);
        chk(win_vertical_split, 1'b1);
        chk(hfb_base, 21'h1fb500);
        apb(1, `PRM_OFF_CTRL, 32'h000000a9);
        apb(1, `PRM_OFF_START, 32'h00000388);
        chk(win_line, 10'h313);
        chk(win_col, 10'h001);
        chk(hfb_base, 21'h1fed40);
        apb(1, 12'h020, 32'h00000001);
        chk(er, 1'b1);
        apb(1, `PRM_OFF_CTRL, 32'h00000000);
        chk(win_vertical_split, 1'b0);
        chk(win_col, 10'h000);
    endtask
    // not selected or register select: no buffer access
    task s_sel;
        for (int k = 0; k < 2; k++)
        begin
            host_cs_n <= (k == 0);
            host_mem_sel <= 1'b0;
            host_valid <= 1'b1;
            repeat (4) @(posedge pclk);
            chk(mem_req, 1'b0);
        end
        host_valid <= 1'b0;
        host_cs_n <= 1'b0;
        host_mem_sel <= 1'b1;
        @(posedge pclk);
    endtask
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, host_valid, host_write, host_byte_addr, host_wdata} = '0;
        host_cs_n = 1'b0;
        host_mem_sel = 1'b1;
        lat = 3'h0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        s_regs;
        s_pass;
        s_rot;
        s_sel;
        s_win;
        conclude;
    end
endmodule
